// ---- bench/stm_pins_model.sv ----
// external trigger and capture pins
`timescale 1ns/100ps
`default_nettype none
module stm_pins_model (
  input  wire logic clk_sys,
  input  wire logic trig_req,
  input  wire logic cap_req,
  output logic      trigger_clock_pin,
  output logic      timer_io_pin_in
);
  // a slow pin: trigger held two cycles so any edge detector sees it
  logic [1:0] hold = 2'h0;
  always_ff @(posedge clk_sys) begin
    hold <= trig_req ? 2'h2 : hold - {1'h0, hold != 2'h0};
  end
  assign trigger_clock_pin = hold != 2'h0;
  assign timer_io_pin_in   = cap_req;
endmodule : stm_pins_model
`default_nettype wire

// ---- bench/stm_timer_monitor.sv ----
// concurrent checks on the standard timer ports
`timescale 1ns/100ps
`default_nettype none
module stm_timer_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        timer_tick,
  input wire logic        pause,
  input wire logic        mode_select_hi,
  input wire logic        mode_select_lo,
  input wire logic        out_function_hi,
  input wire logic        out_function_lo,
  input wire logic        counter_on_set,
  input wire logic        clear_select_bit,
  input wire logic        output_control_bit,
  input wire logic        output_polarity_bit,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_a_value,
  input wire logic        counter_on_bit,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag,
  input wire logic        timer_io_pin_out,
  input wire logic        timer_io_pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a start cycle zeroes the counter instead of stepping it
  logic on_seen;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_seen <= 1'h0;
    end else begin
      on_seen <= counter_on_bit;
    end
  end
  wire logic [1:0] md    = {mode_select_hi, mode_select_lo};
  wire logic [1:0] of    = {out_function_hi, out_function_lo};
  wire logic       step  = counter_on_bit && on_seen && !pause && timer_tick;
  wire logic       hit_a = step && counter_value == compare_a_value;
  sequence s_start;
    $rose(counter_on_bit);
  endsequence
  sequence s_zeroed;
    ##1 counter_value == 16'h0000;
  endsequence
  a_oe_by_mode: assert property (1'h1 |=> timer_io_pin_oe_n == $past(mode_select_lo))
    else $error("pin enable wrong for mode");
  a_no_p_flag: assert property (md[0] == md[1] && clear_select_bit |=> !match_p_flag)
    else $error("p flag with clear by a");
  a_restart_zero: assert property (s_start |-> s_zeroed)
    else $error("counter not zeroed on start");
  a_step_inc: assert property (md == 2'h3 && clear_select_bit && step && !hit_a && !$rose(counter_on_bit)
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("counter did not step");
  a_pwm_flag_a: assert property (md == 2'h2 && of == 2'h2 && hit_a |=> match_a_flag)
    else $error("pwm a flag missing");
  a_pulse_end: assert property (md == 2'h2 && of == 2'h3 && hit_a && !counter_on_set |=> !counter_on_bit)
    else $error("pulse not ended by a match");
  a_pwm_force: assert property (md == 2'h2 && !of[1]
    |=> timer_io_pin_out == $past(output_control_bit ^ output_polarity_bit ^ !out_function_lo))
    else $error("forced pwm level wrong");
  a_init_level: assert property (s_start and md == 2'h0
    |-> ##[0:2] timer_io_pin_out == (output_control_bit ^ output_polarity_bit))
    else $error("pin not at initial level");
endmodule : stm_timer_monitor
bind stm_timer stm_timer_monitor stm_timer_monitor_inst (.clk_sys(clk_sys), .rst(rst), .timer_tick(timer_tick),
  .pause(pause), .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
  .out_function_hi(out_function_hi), .out_function_lo(out_function_lo), .counter_on_set(counter_on_set),
  .clear_select_bit(clear_select_bit), .output_control_bit(output_control_bit),
  .output_polarity_bit(output_polarity_bit), .counter_value(counter_value), .compare_a_value(compare_a_value),
  .counter_on_bit(counter_on_bit), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag),
  .timer_io_pin_out(timer_io_pin_out), .timer_io_pin_oe_n(timer_io_pin_oe_n));
`default_nettype wire

// ---- bench/stm_timer_tb.sv ----
// self-checking bench for the standard timer operating modes
`timescale 1ns/100ps
`default_nettype none
module stm_timer_tb;
  logic clk_sys = 1'h0, rst = 1'h1, tick = 1'h1, pause = 1'h0, ms_h = 1'h0, ms_l = 1'h0, of_h = 1'h0;
  logic of_l = 1'h0, on_set = 1'h0, on_clr = 1'h0, cs = 1'h0, dpx = 1'h0, oc = 1'h0, pol = 1'h0, a_wr = 1'h0;
  logic trig_req = 1'h0, cap_req = 1'h0, trig_pin, cap_pin, on_bit, fa, fp, pin, oe_n;
  logic [15:0] a_wd = 16'h0000, cnt, a_val;
  logic [7:0]  p_val = 8'h00;
  int num_errors = 0, total_checks = 0, ca, cp, chi, pa, pp, d;
  stm_timer stm_timer_inst (.clk_sys(clk_sys), .rst(rst), .timer_tick(tick), .pause(pause),
    .mode_select_hi(ms_h), .mode_select_lo(ms_l), .out_function_hi(of_h), .out_function_lo(of_l),
    .counter_on_set(on_set), .counter_on_clr(on_clr), .clear_select_bit(cs), .period_duty_swap_bit(dpx),
    .output_control_bit(oc), .output_polarity_bit(pol), .compare_a_wdata(a_wd), .compare_a_wr(a_wr),
    .compare_p_value(p_val), .trigger_clock_pin(trig_pin), .trigger_rising(1'h1), .timer_io_pin_in(cap_pin),
    .counter_on_bit(on_bit), .counter_value(cnt), .compare_a_value(a_val), .match_a_flag(fa),
    .match_p_flag(fp), .timer_io_pin_out(pin), .timer_io_pin_oe_n(oe_n));
  stm_pins_model stm_pins_model_inst (.clk_sys(clk_sys), .trig_req(trig_req), .cap_req(cap_req),
    .trigger_clock_pin(trig_pin), .timer_io_pin_in(cap_pin));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tk
  // stops the counter in the same write as the new mode: mode changes while running are undefined
  task automatic cfg(input logic [1:0] m, input logic [1:0] f, input logic [3:0] b, input logic [7:0] p,
                     input logic [15:0] a);
    @(posedge clk_sys);
    {on_clr, a_wr, ms_h, ms_l, of_h, of_l, cs, dpx, oc, pol, p_val, a_wd} <= {2'h3, m, f, b, p, a};
    @(posedge clk_sys);
    {on_clr, a_wr} <= 2'h0;
  endtask : cfg
  task automatic go();
    @(posedge clk_sys);
    on_set <= 1'h1;
    @(posedge clk_sys);
    on_set <= 1'h0;
  endtask : go
  task automatic watch(input int n);
    int la = 0, lp = 0;
    {ca, cp, chi, pa, pp} = '0;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk_sys);
      #1;
      chi += int'(pin === 1'h1);
      if (fa === 1'h1) begin
        if (la > 0) pa = i - la;
        la = i;
        ca++;
      end
      if (fp === 1'h1) begin
        if (lp > 0) pp = i - lp;
        lp = i;
        cp++;
      end
    end
  endtask : watch
  task automatic pw(input logic [1:0] f, input logic [3:0] b, input int a, input logic [7:0] p, input int n,
                    input int exp);
    cfg(2'h2, f, b, p, a[15:0]);
    go();
    tk(4);
    watch(n);
    chk(chi, exp);
  endtask : pw
  initial begin
    tk(100000);
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h28e6));
    d = 16 + $urandom % 224;
    tk(5);
    rst <= 1'h0;
    cfg(2'h0, 2'h3, 4'h0, 8'h01, 16'h0040);
    go();
    watch(700);
    chk(pp, 256);
    chk({ca, cp}, {32'd3, 32'd2});
    chk(chi, 378);
    for (int m = 0; m < 4; m += 3) begin
      // a above 0xff so the suppressed p match really occurs each period
      cfg(m[1:0], 2'h3, 4'h8, 8'h01, 16'h0120);
      go();
      watch(600);
      chk({pa, cp}, {32'd289, 32'd0});
    end
    chk(oe_n, 1'h1);
    pw(2'h2, 4'h2, d, 8'h01, 256, d);
    chk({ca, cp}, {32'd1, 32'd1});
    pw(2'h2, 4'hb, d, 8'h01, 256, 256 - d);
    pw(2'h2, 4'h2, 16'h0200, 8'h01, 256, 256);
    pw(2'h2, 4'h6, 16'h01ff, 8'h01, 512, 256);
    pw(2'h2, 4'h6, 16'h01ff, 8'h00, 512, 512);
    pw(2'h1, 4'h2, d, 8'h01, 256, 256);
    pw(2'h0, 4'h2, d, 8'h01, 256, 0);
    chk(ca, 1);
    cfg(2'h2, 2'h3, 4'h2, 8'h00, 16'h0020);
    trig_req <= 1'h1;
    tk(1);
    trig_req <= 1'h0;
    watch(100);
    chk({chi, ca, 31'h0, on_bit}, {32'd34, 32'd1, 32'd0});
    chk(cnt, 16'h0021);
    go();
    tk(5);
    on_clr <= 1'h1;
    tk(1);
    on_clr <= 1'h0;
    tk(3);
    chk(pin, 1'h0);
    pause <= 1'h1;
    for (int f = 0; f < 4; f++) begin
      cfg(2'h1, f[1:0], 4'h0, 8'h00, 16'hffff);
      go();
      tk(1);
      cap_req <= 1'h1;
      tk(4);
      chk(a_val, (f % 2) ? 16'hffff : 16'h0000);
      cfg(2'h1, f[1:0], 4'h0, 8'h00, 16'hffff);
      cap_req <= 1'h0;
      tk(4);
      chk(a_val, (f == 1 || f == 2) ? 16'h0000 : 16'hffff);
    end
    results();
  end
endmodule : stm_timer_tb
`default_nettype wire

// ---- hw/stm_cnt_if.sv ----
// counter-to-comparator signal bundle
`timescale 1ns/100ps
`default_nettype none
interface stm_cnt_if;
  import stm_pkg::*;
  stm_count_t count;
  logic [15:0] cmp_a;
  logic [7:0]  cmp_p;
  logic        match_a;
  logic        match_p;
  modport cnt (output count, input cmp_a, input cmp_p, input match_a, input match_p);
  modport cmp (input count, input cmp_a, input cmp_p, output match_a, output match_p);
endinterface : stm_cnt_if
`default_nettype wire

// ---- hw/stm_compare.sv ----
// comparators A and P against the counter
`timescale 1ns/100ps
`default_nettype none
`include "stm_params.svh"
module stm_compare
  import stm_pkg::*;
(
  stm_cnt_if.cmp bus
);
  // p looks only at the top byte and fires on the last count before that byte
  // would reach p, so the span is p*256 ticks; zero wraps to the full 16 bits
  logic [7:0] top_next;
  always_comb begin
    bus.match_a = (bus.count == bus.cmp_a);
    top_next    = bus.count[15:`STM_P_LSB] + 8'h01;
    bus.match_p = (top_next == bus.cmp_p) && (bus.count[7:0] == 8'hff);
  end
endmodule : stm_compare
`default_nettype wire

// ---- hw/stm_edge.sv ----
// one-cycle rising/falling edge detector
`timescale 1ns/100ps
`default_nettype none
module stm_edge (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  logic prev;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end
  assign rise = sig & ~prev;
  assign fall = ~sig & prev;
endmodule : stm_edge
`default_nettype wire

// ---- hw/stm_params.svh ----
// constants for the standard timer operating-mode block
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
`define STM_MODE_CMP      2'h0
`define STM_MODE_CAP      2'h1
`define STM_MODE_PWM      2'h2
`define STM_MODE_TMR      2'h3
`define STM_OF_PWM        2'h2
`define STM_OF_PULSE      2'h3
`define STM_CAP_RISE      2'h0
`define STM_CAP_FALL      2'h1
`define STM_CAP_BOTH      2'h2
`define STM_CAP_OFF       2'h3
`define STM_CNT_RESET     16'h0000
`define STM_CAPT_RESET    16'h0000
`define STM_P_LSB         8
`endif

// ---- hw/stm_pkg.sv ----
// types for the standard timer operating-mode block
package stm_pkg;
  typedef enum logic [1:0] {
    stm_cmp = 2'b00,
    stm_cap = 2'b01,
    stm_pwm = 2'b10,
    stm_tmr = 2'b11
  } stm_mode_e;
  typedef logic [15:0] stm_count_t;
endpackage : stm_pkg

// ---- hw/stm_timer.sv ----
// standard timer operating modes: compare, timer, pwm, single pulse, capture
`timescale 1ns/100ps
`default_nettype none
`include "stm_params.svh"
module stm_timer
  import stm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        timer_tick,
  input  wire logic        pause,
  input  wire logic        mode_select_hi,
  input  wire logic        mode_select_lo,
  input  wire logic        out_function_hi,
  input  wire logic        out_function_lo,
  input  wire logic        counter_on_set,
  input  wire logic        counter_on_clr,
  input  wire logic        clear_select_bit,
  input  wire logic        period_duty_swap_bit,
  input  wire logic        output_control_bit,
  input  wire logic        output_polarity_bit,
  input  wire logic [15:0] compare_a_wdata,
  input  wire logic        compare_a_wr,
  input  wire logic [7:0]  compare_p_value,
  input  wire logic        trigger_clock_pin,
  input  wire logic        trigger_rising,
  input  wire logic        timer_io_pin_in,
  output logic             counter_on_bit,
  output logic [15:0]      counter_value,
  output logic [15:0]      compare_a_value,
  output logic             match_a_flag,
  output logic             match_p_flag,
  output logic             timer_io_pin_out,
  output logic             timer_io_pin_oe_n
);
  stm_cnt_if cbus ();
  stm_mode_e  mode;
  logic [1:0] ofn;
  logic       on_rise;
  logic       on_fall;
  logic       trg_rise;
  logic       trg_fall;
  logic       cap_rise;
  logic       cap_fall;
  logic       step;
  logic       match_a;
  logic       match_p;
  logic       clr_cnt;
  logic       pwm_sel;
  logic       pulse_sel;
  logic       cap_edge;
  logic       pwm_active;
  logic       cmp_pin;
  logic       next_pin;
  logic [16:0] period_len;
  logic [16:0] duty_len;

  assign mode = stm_mode_e'({mode_select_hi, mode_select_lo});
  assign ofn  = {out_function_hi, out_function_lo};
  assign pwm_sel   = (mode == stm_pwm) && (ofn != `STM_OF_PULSE);
  assign pulse_sel = (mode == stm_pwm) && (ofn == `STM_OF_PULSE);

  stm_edge u_on_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sig     (counter_on_bit),
    .rise    (on_rise),
    .fall    (on_fall)
  );
  stm_edge u_trg_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sig     (trigger_clock_pin),
    .rise    (trg_rise),
    .fall    (trg_fall)
  );
  stm_edge u_cap_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sig     (timer_io_pin_in),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  assign cbus.count = counter_value;
  assign cbus.cmp_a = compare_a_value;
  assign cbus.cmp_p = compare_p_value;
  stm_compare u_cmp (
    .bus (cbus)
  );

  // matches count only on a real tick, so each fires once per pass
  assign step    = counter_on_bit && !pause && timer_tick && !on_rise;
  assign match_a = step && cbus.match_a;
  assign match_p = step && cbus.match_p;

  always_comb begin
    case (mode)
      stm_cmp, stm_tmr: clr_cnt = clear_select_bit ? match_a : match_p;
      stm_pwm:          clr_cnt = pulse_sel ? 1'b0 :
                                  (period_duty_swap_bit ? match_a : match_p);
      stm_cap:          clr_cnt = match_p;
      default:          clr_cnt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      counter_value <= `STM_CNT_RESET;
    end else if (on_rise) begin
      counter_value <= `STM_CNT_RESET;
    end else if (step) begin
      counter_value <= clr_cnt ? `STM_CNT_RESET : counter_value + 16'h0001;
    end
  end

  // counter-on: software set/clear, pin trigger and A match in pulse mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      counter_on_bit <= 1'b0;
    end else if (counter_on_set || (pulse_sel && (trigger_rising ? trg_rise : trg_fall))) begin
      counter_on_bit <= 1'b1;
    end else if (counter_on_clr || (pulse_sel && match_a)) begin
      counter_on_bit <= 1'b0;
    end
  end

  // flags stay high one cycle; set by hardware only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= match_a || (mode == stm_cap && cap_edge);
      match_p_flag <= match_p && !pulse_sel &&
                      !((mode == stm_cmp || mode == stm_tmr) && clear_select_bit);
    end
  end

  always_comb begin
    case (ofn)
      `STM_CAP_RISE: cap_edge = cap_rise;
      `STM_CAP_FALL: cap_edge = cap_fall;
      `STM_CAP_BOTH: cap_edge = cap_rise | cap_fall;
      default:       cap_edge = 1'b0;
    endcase
  end

  // capture works whether or not the counter is on; software writes land when no capture is due
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compare_a_value <= `STM_CAPT_RESET;
    end else if (mode == stm_cap && cap_edge) begin
      compare_a_value <= counter_value;
    end else if (compare_a_wr) begin
      compare_a_value <= compare_a_wdata;
    end
  end

  // 17-bit lengths so a zero P value reads as a full 65536-tick span
  always_comb begin
    if (period_duty_swap_bit) begin
      period_len = {1'b0, compare_a_value};
      duty_len   = (compare_p_value == 8'h00) ? 17'h10000 : {1'b0, compare_p_value, 8'h00};
    end else begin
      period_len = (compare_p_value == 8'h00) ? 17'h10000 : {1'b0, compare_p_value, 8'h00};
      duty_len   = {1'b0, compare_a_value};
    end
    pwm_active = ({1'b0, counter_value} < duty_len) || (duty_len >= period_len);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_pin <= 1'b0;
    end else if (on_rise) begin
      cmp_pin <= output_control_bit;
    end else if (mode == stm_cmp && match_a) begin
      case (ofn)
        2'h1:    cmp_pin <= 1'b0;
        2'h2:    cmp_pin <= 1'b1;
        2'h3:    cmp_pin <= ~cmp_pin;
        default: cmp_pin <= cmp_pin;
      endcase
    end
  end

  always_comb begin
    case (mode)
      stm_cmp: next_pin = cmp_pin ^ output_polarity_bit;
      stm_pwm: begin
        if (pulse_sel) begin
          next_pin = counter_on_bit;
        end else if (ofn == 2'h0) begin
          next_pin = 1'b0;
        end else if (ofn == 2'h1) begin
          next_pin = 1'b1;
        end else begin
          next_pin = pwm_active && counter_on_bit;
        end
        // active level from output control, then optional inversion
        next_pin = (output_control_bit ? next_pin : ~next_pin) ^ output_polarity_bit;
      end
      default: next_pin = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_io_pin_out  <= 1'b0;
      timer_io_pin_oe_n <= 1'b1;
    end else begin
      timer_io_pin_out  <= next_pin;
      timer_io_pin_oe_n <= !(mode == stm_cmp || mode == stm_pwm);
    end
  end

  logic unused_ok;
  assign unused_ok = on_fall;
endmodule : stm_timer
`default_nettype wire
